/* verilog/pol_protection_pkg.sv */
// Constants shared by the protection status and threshold register bank.
package pol_protection_pkg;

    // Register select codes on the internal register port.
    localparam logic [1:0] SEL_PROTECTION_FLAGS = 2'h0;
    localparam logic [1:0] SEL_CURRENT_LIMIT    = 2'h1;
    localparam logic [1:0] SEL_THRESHOLD_CONFIG = 2'h2;

    // Reset values loaded at power-on reset, and the threshold register write mask.
    localparam logic [7:0] FLAGS_RESET     = 8'hBF;
    localparam logic [7:0] CLS_RESET       = 8'h1B;
    localparam logic [7:0] THR_RESET       = 8'h08;
    localparam logic [7:0] THR_WRITE_MASK  = 8'h1F;

    // Field positions in protection_flags.
    localparam int FLAG_HEAT_WARNING   = 7;
    localparam int FLAG_OUTPUT_GOOD    = 6;
    localparam int FLAG_SLEW_FOLLOW    = 5;
    localparam int FLAG_HEAT_FAULT     = 4;
    localparam int FLAG_EXCESS_LOAD    = 3;
    localparam int FLAG_LOW_OUTPUT     = 2;
    localparam int FLAG_HIGH_OUTPUT    = 1;
    localparam int FLAG_PHASE_DRIVE    = 0;

    // Field positions in current_limit_setting and threshold_config.
    localparam int DROOP_MSB           = 7;
    localparam int DROOP_LSB           = 5;
    localparam int HEAT_COMP_BIT       = 4;
    localparam int CL_MSB              = 3;
    localparam int CL_LSB              = 0;
    localparam int GOOD_FLOOR_BIT      = 4;
    localparam int HIGH_TRIP_MSB       = 3;
    localparam int HIGH_TRIP_LSB       = 2;
    localparam int LOW_TRIP_MSB        = 1;
    localparam int LOW_TRIP_LSB        = 0;

    // Current limit code ceiling.
    localparam logic [3:0] CL_CODE_MAX = 4'hB;

    // Power Good upper limit, percent of setpoint.
    localparam logic [7:0] GOOD_HIGH_PCT = 8'h6E;

endpackage

/* verilog/pol_protection_registers.sv */
// Protection status flags and threshold configuration registers of a point-of-load converter.
//
// Operation
// - Active warning, fault or error reads as zero; inactive reads as one.
// - Flag bits 7..0: heat warn, good warn, slew, heat, load, low, high, phase.
// - Droop field bits 7:5 decodes to slopes 0, 0.39, 1.18, 1.57, 2.35.
// - Current limit code bits 3:0; codes above Bh act as Bh.
// - High trip 110/120/130/130 percent; low trip 75/80/85/90 percent.
// - Host writes current limit and threshold registers; device applies them.
// - Heat compensation of current limit follows the enable bit.
// - Power Good floor bit selects 95 percent when one, 90 when zero.
// - Trip and Power Good levels scale with the present output setpoint.
`timescale 1ns/100ps
module pol_protection_registers (
    input  wire logic        clk,
    input  wire logic        rst_b,
    input  wire logic [1:0]  reg_sel,
    input  wire logic        reg_wr,
    input  wire logic [7:0]  reg_wdata,
    output logic      [7:0]  reg_rdata,
    input  wire logic        heat_warning_in,
    input  wire logic        output_good_warning_in,
    input  wire logic        slew_follow_fault_in,
    input  wire logic        heat_fault_in,
    input  wire logic        excess_load_fault_in,
    input  wire logic        low_output_fault_in,
    input  wire logic        high_output_error_in,
    input  wire logic [15:0] vout_setpoint,
    output logic      [7:0]  droop_slope_centi,
    output logic             droop_slope_valid,
    output logic      [3:0]  current_limit_code,
    output logic             heat_comp_en,
    output logic      [7:0]  high_trip_pct,
    output logic      [7:0]  low_trip_pct,
    output logic      [7:0]  good_floor_pct,
    output logic      [15:0] high_trip_level,
    output logic      [15:0] low_trip_level,
    output logic      [15:0] good_high_level,
    output logic      [15:0] good_low_level
);

    // Scales a setpoint by a percentage; the product fits 24 bits.
    function automatic logic [15:0] scale_pct(input logic [15:0] v, input logic [7:0] pct);
        logic [23:0] prod;
        prod = {8'h00, v} * {16'h0000, pct};
        return 16'(prod / 24'd100);
    endfunction

    logic [7:0] flags_q;
    logic [7:0] cls_q;
    logic [7:0] thr_q;
    logic [7:0] flags_d;
    logic       wr_cls;
    logic       wr_thr;
    logic       wr_flags;
    logic [7:0] rdata_d;
    logic [2:0] droop_code;
    logic [3:0] cl_raw;
    logic [3:0] cl_eff;
    logic [7:0] droop_d;
    logic       droop_ok;
    logic [7:0] high_pct_d;
    logic [7:0] low_pct_d;
    logic [7:0] floor_pct_d;

    assign flags_d[pol_protection_pkg::FLAG_HEAT_WARNING] = ~heat_warning_in;
    assign flags_d[pol_protection_pkg::FLAG_OUTPUT_GOOD]  = ~output_good_warning_in;
    assign flags_d[pol_protection_pkg::FLAG_SLEW_FOLLOW]  = ~slew_follow_fault_in;
    assign flags_d[pol_protection_pkg::FLAG_HEAT_FAULT]   = ~heat_fault_in;
    assign flags_d[pol_protection_pkg::FLAG_EXCESS_LOAD]  = ~excess_load_fault_in;
    assign flags_d[pol_protection_pkg::FLAG_LOW_OUTPUT]   = ~low_output_fault_in;
    assign flags_d[pol_protection_pkg::FLAG_HIGH_OUTPUT]  = ~high_output_error_in;
    // The phase drive check is not active, so its flag always reads inactive.
    assign flags_d[pol_protection_pkg::FLAG_PHASE_DRIVE]  = 1'b1;

    assign wr_cls   = reg_wr && (reg_sel == pol_protection_pkg::SEL_CURRENT_LIMIT);
    assign wr_thr   = reg_wr && (reg_sel == pol_protection_pkg::SEL_THRESHOLD_CONFIG);
    assign wr_flags = reg_wr && (reg_sel == pol_protection_pkg::SEL_PROTECTION_FLAGS);

    assign rdata_d = (reg_sel == pol_protection_pkg::SEL_PROTECTION_FLAGS) ? flags_q :
                     (reg_sel == pol_protection_pkg::SEL_CURRENT_LIMIT)    ? cls_q   :
                     (reg_sel == pol_protection_pkg::SEL_THRESHOLD_CONFIG) ? thr_q   :
                     8'h00;

    assign droop_code = cls_q[pol_protection_pkg::DROOP_MSB:pol_protection_pkg::DROOP_LSB];
    assign cl_raw     = cls_q[pol_protection_pkg::CL_MSB:pol_protection_pkg::CL_LSB];
    assign cl_eff     = (cl_raw > pol_protection_pkg::CL_CODE_MAX) ?
                        pol_protection_pkg::CL_CODE_MAX : cl_raw;

    // Codes 010, 110 and 111 have no defined slope; they give zero and drop valid.
    assign droop_ok = (droop_code == 3'h0) || (droop_code == 3'h1) || (droop_code == 3'h3) ||
                      (droop_code == 3'h4) || (droop_code == 3'h5);
    assign droop_d  = (droop_code == 3'h1) ? 8'h27 :
                      (droop_code == 3'h3) ? 8'h76 :
                      (droop_code == 3'h4) ? 8'h9D :
                      (droop_code == 3'h5) ? 8'hEB : 8'h00;

    assign high_pct_d = (thr_q[pol_protection_pkg::HIGH_TRIP_MSB:pol_protection_pkg::HIGH_TRIP_LSB]
                         == 2'h0) ? 8'h6E :
                        (thr_q[pol_protection_pkg::HIGH_TRIP_MSB:pol_protection_pkg::HIGH_TRIP_LSB]
                         == 2'h1) ? 8'h78 : 8'h82;
    assign low_pct_d  = (thr_q[pol_protection_pkg::LOW_TRIP_MSB:pol_protection_pkg::LOW_TRIP_LSB]
                         == 2'h0) ? 8'h4B :
                        (thr_q[pol_protection_pkg::LOW_TRIP_MSB:pol_protection_pkg::LOW_TRIP_LSB]
                         == 2'h1) ? 8'h50 :
                        (thr_q[pol_protection_pkg::LOW_TRIP_MSB:pol_protection_pkg::LOW_TRIP_LSB]
                         == 2'h2) ? 8'h55 : 8'h5A;
    assign floor_pct_d = thr_q[pol_protection_pkg::GOOD_FLOOR_BIT] ? 8'h5F : 8'h5A;

    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            flags_q   <= pol_protection_pkg::FLAGS_RESET;
            cls_q     <= pol_protection_pkg::CLS_RESET;
            thr_q     <= pol_protection_pkg::THR_RESET;
            reg_rdata <= 8'h00;
        end
        else
        begin
            flags_q   <= flags_d;
            reg_rdata <= rdata_d;
            if (wr_cls)
                cls_q <= reg_wdata;
            if (wr_thr)
                thr_q <= reg_wdata & pol_protection_pkg::THR_WRITE_MASK;
        end
    end

    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            droop_slope_centi  <= 8'h00;
            droop_slope_valid  <= 1'b0;
            current_limit_code <= 4'h0;
            heat_comp_en       <= 1'b0;
            high_trip_pct      <= 8'h00;
            low_trip_pct       <= 8'h00;
            good_floor_pct     <= 8'h00;
        end
        else
        begin
            droop_slope_centi  <= droop_d;
            droop_slope_valid  <= droop_ok;
            current_limit_code <= cl_eff;
            heat_comp_en       <= cls_q[pol_protection_pkg::HEAT_COMP_BIT];
            high_trip_pct      <= high_pct_d;
            low_trip_pct       <= low_pct_d;
            good_floor_pct     <= floor_pct_d;
        end
    end

    // Absolute levels track every setpoint change one cycle later.
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            high_trip_level <= 16'h0000;
            low_trip_level  <= 16'h0000;
            good_high_level <= 16'h0000;
            good_low_level  <= 16'h0000;
        end
        else
        begin
            high_trip_level <= scale_pct(vout_setpoint, high_pct_d);
            low_trip_level  <= scale_pct(vout_setpoint, low_pct_d);
            good_high_level <= scale_pct(vout_setpoint, pol_protection_pkg::GOOD_HIGH_PCT);
            good_low_level  <= scale_pct(vout_setpoint, floor_pct_d);
        end
    end

    AST_FLAG_ACTIVE_LOW: assert property (@(posedge clk) disable iff (!rst_b)
        rst_b && heat_fault_in |=> !flags_q[pol_protection_pkg::FLAG_HEAT_FAULT])
        else $error("heat fault not reported as zero");

    AST_FLAG_MAP: assert property (@(posedge clk) disable iff (!rst_b)
        $past(rst_b) |-> flags_q[pol_protection_pkg::FLAG_PHASE_DRIVE] &&
        (flags_q[pol_protection_pkg::FLAG_HEAT_WARNING] != $past(heat_warning_in)))
        else $error("flag map wrong");

    AST_DROOP_DECODE: assert property (@(posedge clk) disable iff (!rst_b)
        (droop_code == 3'h5) |=> (droop_slope_centi == 8'hEB) && droop_slope_valid)
        else $error("droop slope decode wrong");

    AST_CL_CLAMP: assert property (@(posedge clk) disable iff (!rst_b)
        (cl_raw > 4'hB) |=> (current_limit_code == 4'hB))
        else $error("current limit code not clamped");

    AST_TRIP_DECODE: assert property (@(posedge clk) disable iff (!rst_b)
        (thr_q[3:0] == 4'hC) |=> (high_trip_pct == 8'h82) && (low_trip_pct == 8'h4B))
        else $error("trip level decode wrong");

    AST_WRITE_APPLIES: assert property (@(posedge clk) disable iff (!rst_b)
        rst_b && wr_cls ##1 !wr_cls |=> (cls_q == $past(reg_wdata, 2)) &&
        (current_limit_code == (($past(reg_wdata[3:0], 2) > 4'hB) ?
                                4'hB : $past(reg_wdata[3:0], 2))))
        else $error("written current limit not applied");

    AST_HEAT_COMP: assert property (@(posedge clk) disable iff (!rst_b)
        rst_b && wr_cls ##1 !wr_cls |=> (heat_comp_en == $past(reg_wdata[4], 2)))
        else $error("heat compensation enable not followed");

    AST_GOOD_FLOOR: assert property (@(posedge clk) disable iff (!rst_b)
        thr_q[pol_protection_pkg::GOOD_FLOOR_BIT] |=> (good_floor_pct == 8'h5F))
        else $error("power good floor wrong");

    AST_SETPOINT_TRACK: assert property (@(posedge clk) disable iff (!rst_b)
        rst_b && $stable(thr_q) |=>
        (good_high_level == 16'((24'(($past(vout_setpoint))) * 24'd110) / 24'd100)))
        else $error("power good high level does not follow setpoint");

    AST_FLAGS_READONLY: assert property (@(posedge clk) disable iff (!rst_b)
        wr_flags |=> $stable(cls_q) && $stable(thr_q) && (thr_q[7:5] == 3'h0))
        else $error("flag write disturbed configuration");

    AST_THR_WRITE_MASK: assert property (@(posedge clk) disable iff (!rst_b)
        rst_b && wr_thr |=> (thr_q == ($past(reg_wdata) & 8'h1F)))
        else $error("threshold write not masked");

    AST_UNMAPPED_READ: assert property (@(posedge clk) disable iff (!rst_b)
        (reg_sel == 2'h3) |=> (reg_rdata == 8'h00))
        else $error("unmapped register does not read zero");

endmodule

/* verification/pol_host_model.sv */
// Host side model that drives the register port of the protection register bank.
`timescale 1ns/100ps
module pol_host_model (
    input  wire logic       clk,
    output logic      [1:0] reg_sel,
    output logic            reg_wr,
    output logic      [7:0] reg_wdata
);
    initial
    begin
        reg_sel   = 2'h0;
        reg_wr    = 1'b0;
        reg_wdata = 8'h00;
    end

    // Write data is inverted once the write is taken, so a stale value is never read as valid.
    task automatic wr(input logic [1:0] s, input logic [7:0] d);
        @(posedge clk);
        reg_sel   <= s;
        reg_wr    <= 1'b1;
        reg_wdata <= d;
        @(posedge clk);
        reg_wr    <= 1'b0;
        reg_wdata <= ~d;
    endtask

    task automatic setsel(input logic [1:0] s);
        @(posedge clk);
        reg_sel <= s;
        @(posedge clk);
    endtask
endmodule

/* verification/pol_protection_registers_bench.sv */
// Self-checking bench for the protection register bank.
`timescale 1ns/100ps
module pol_protection_registers_bench;
    logic        clk, rst_b, reg_wr, droop_slope_valid, heat_comp_en;
    logic [1:0]  reg_sel;
    logic [3:0]  current_limit_code;
    logic [6:0]  cond;
    logic [7:0]  reg_wdata, reg_rdata, droop_slope_centi, high_trip_pct, low_trip_pct;
    logic [7:0]  good_floor_pct, exp_cls, exp_thr, v;
    logic [15:0] vout_setpoint, high_trip_level, low_trip_level, good_high_level, good_low_level;
    logic [31:0] seed;
    int          n_mismatch, checks, cycles, i;
    int          sl[8] = '{0, 39, 0, 118, 157, 235, 0, 0};
    int          hp[4] = '{110, 120, 130, 130};
    int          lp[4] = '{75, 80, 85, 90};

    pol_protection_registers i_pol_protection_registers (.clk(clk), .rst_b(rst_b),
        .reg_sel(reg_sel), .reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
        .heat_warning_in(cond[6]), .output_good_warning_in(cond[5]),
        .slew_follow_fault_in(cond[4]), .heat_fault_in(cond[3]),
        .excess_load_fault_in(cond[2]), .low_output_fault_in(cond[1]),
        .high_output_error_in(cond[0]), .vout_setpoint(vout_setpoint),
        .droop_slope_centi(droop_slope_centi), .droop_slope_valid(droop_slope_valid),
        .current_limit_code(current_limit_code), .heat_comp_en(heat_comp_en),
        .high_trip_pct(high_trip_pct), .low_trip_pct(low_trip_pct),
        .good_floor_pct(good_floor_pct), .high_trip_level(high_trip_level),
        .low_trip_level(low_trip_level), .good_high_level(good_high_level),
        .good_low_level(good_low_level));
    pol_host_model i_pol_host_model (.clk(clk), .reg_sel(reg_sel), .reg_wr(reg_wr),
        .reg_wdata(reg_wdata));

    initial
    begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end

    function logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction

    task check(input logic [15:0] seen, input logic [15:0] exp);
        checks++;
        if (seen !== exp)
        begin
            n_mismatch++;
            $display("ERROR %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task rd(input logic [1:0] s, input logic [7:0] exp);
        i_pol_host_model.setsel(s);
        #1 check(reg_rdata, exp);
    endtask

    // Expected decoded outputs are rebuilt from the shadow copies of the two registers.
    task chk_cfg();
        int t, h, l, f;
        t = exp_thr;
        h = hp[t[3:2]];
        l = lp[t[1:0]];
        f = t[4] ? 95 : 90;
        check(droop_slope_centi, sl[exp_cls[7:5]]);
        check(droop_slope_valid, exp_cls[7:5] inside {0, 1, 3, 4, 5});
        check(current_limit_code, exp_cls[3:0] > 11 ? 11 : exp_cls[3:0]);
        check(heat_comp_en, exp_cls[4]);
        check(high_trip_pct, h);
        check(low_trip_pct, l);
        check(good_floor_pct, f);
        check(high_trip_level, vout_setpoint * h / 100);
        check(low_trip_level, vout_setpoint * l / 100);
        check(good_high_level, vout_setpoint * 110 / 100);
        check(good_low_level, vout_setpoint * f / 100);
    endtask

    task conclude();
        $display("checks %0d mismatches %0d", checks, n_mismatch);
        if (n_mismatch == 0 && checks > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    always @(posedge clk)
    begin
        cycles <= cycles + 1;
        if (cycles == 2000)
        begin
            n_mismatch++;
            conclude();
        end
    end

    initial
    begin
        rst_b = 1'b0;
        cond = 7'h00;
        vout_setpoint = 16'h0FA0;
        seed = 29763;
        n_mismatch = 0;
        checks = 0;
        cycles = 0;
        exp_cls = 8'h1B;
        exp_thr = 8'h08;
        repeat (3) @(posedge clk);
        rst_b <= 1'b1;
        @(posedge clk);
        #1 chk_cfg();
        rd(2'h1, 8'h1B);
        rd(2'h2, 8'h08);
        rd(2'h3, 8'h00);
        rd(2'h0, 8'hFF);
        $display("test reset done");
        for (i = 0; i < 23; i++)
        begin
            @(posedge clk);
            cond <= (i < 7) ? 7'(1 << i) : rnd();
            i_pol_host_model.wr(2'h0, rnd());
            rd(2'h0, {~cond, 1'b1});
        end
        $display("test flags done");
        for (i = 0; i < 24; i++)
        begin
            v = (i < 16) ? ((rnd() & 8'hF0) | 8'(i)) : rnd();
            i_pol_host_model.wr(2'h1, v);
            exp_cls = v;
            i_pol_host_model.wr(2'h3, ~v);
            repeat (3) @(posedge clk);
            #1 chk_cfg();
            rd(2'h1, v);
        end
        $display("test current limit done");
        for (i = 0; i < 40; i++)
        begin
            v = (i < 32) ? ((rnd() & 8'hE0) | 8'(i)) : rnd();
            @(posedge clk);
            vout_setpoint <= rnd() & 16'h3FFF;
            i_pol_host_model.wr(2'h2, v);
            exp_thr = v & 8'h1F;
            repeat (3) @(posedge clk);
            #1 chk_cfg();
            rd(2'h2, exp_thr);
        end
        $display("test thresholds done");
        @(posedge clk);
        rst_b <= 1'b0;
        repeat (2) @(posedge clk);
        rst_b <= 1'b1;
        exp_cls = 8'h1B;
        exp_thr = 8'h08;
        @(posedge clk);
        #1 chk_cfg();
        rd(2'h1, 8'h1B);
        rd(2'h2, 8'h08);
        rd(2'h0, {~cond, 1'b1});
        $display("test mid-run reset done");
        for (i = 0; i < 8; i++)
        begin
            @(posedge clk);
            vout_setpoint <= rnd() & 16'h3FFF;
            repeat (2) @(posedge clk);
            #1 chk_cfg();
        end
        $display("test setpoint done");
        conclude();
    end
endmodule
